// File: design/cdam_map.vh
`ifndef CDAM_MAP_VH
`define CDAM_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CDAM_OFF_STAT 8'h01
`define CDAM_OFF_GATE 8'h03
`define CDAM_OFF_PACE 8'h07
`define CDAM_OFF_SKIP 8'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CDAM_RST_STAT 8'h00
`define CDAM_RST_GATE 8'h00
`define CDAM_RST_PACE 8'h00
`define CDAM_RST_SKIP 8'h00
`define CDAM_RDATA_NONE 8'h00

// ----------------------------------------------------------------
// Input configurations and the bits each one implements
// ----------------------------------------------------------------
`define CDAM_MODE_0 2'h0
`define CDAM_MODE_1 2'h1
`define CDAM_MODE_2 2'h2
`define CDAM_MODE_3 2'h3
`define CDAM_LEGAL_M0 8'hff
`define CDAM_LEGAL_M1 8'hff
`define CDAM_LEGAL_M2 8'h8f
`define CDAM_LEGAL_M3 8'hbf

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CDAM_PACE_RATE_BIT 0
`define CDAM_PACE_LEGAL 8'h01
`define CDAM_READ_ZERO 12'h000
`define CDAM_SLOT_FIRST 3'h0

`endif

// File: design/cdam_mode_mask.v
`timescale 1ns/100ps
`include "cdam_map.vh"

module cdam_mode_mask (
  input wire [1:0] cfg_mode, // Input configuration
  output reg [7:0] legal_bits // Bits implemented in this mode
);

  // --------------------------------------------------------------
  // Implemented bits per configuration
  // --------------------------------------------------------------
  always @* begin
    case (cfg_mode)
      `CDAM_MODE_0: legal_bits = `CDAM_LEGAL_M0;
      `CDAM_MODE_1: legal_bits = `CDAM_LEGAL_M1;
      `CDAM_MODE_2: legal_bits = `CDAM_LEGAL_M2;
      default: legal_bits = `CDAM_LEGAL_M3;
    endcase
  end

endmodule

// File: design/cdam_alarm_status.v
`timescale 1ns/100ps
`include "cdam_map.vh"

module cdam_alarm_status (
  input wire clk_sys, // System clock
  input wire rst_b, // Synchronous reset, active low
  input wire ce, // Clock enable
  input wire [7:0] alarm_evt, // Limit exceeded, per slot
  input wire [7:0] legal_bits, // Implemented slots
  input wire [7:0] skip_bits, // Disabled slots
  input wire [7:0] gate_bits, // Interrupt mask
  input wire clr_all, // Return to reset value
  input wire clr_read, // Status read by host
  output reg [7:0] stat_r, // Sticky status
  output reg int_b_r // Interrupt, active low
);

  reg [7:0] stat_nxt;
  wire [7:0] evt_live;

  // Disabled channels raise nothing
  assign evt_live = alarm_evt & legal_bits & ~skip_bits;

  // --------------------------------------------------------------
  // Sticky status, set wins over clear
  // --------------------------------------------------------------
  always @* begin
    stat_nxt = stat_r;
    if (clr_all || clr_read) begin
      stat_nxt = `CDAM_RST_STAT;
    end
    stat_nxt = stat_nxt | evt_live;
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      stat_r <= `CDAM_RST_STAT;
      int_b_r <= 1'b1;
    end else if (ce) begin
      stat_r <= stat_nxt;
      // Masked bits stay recorded but do not pull the pin
      int_b_r <= ~|(stat_nxt & ~gate_bits & legal_bits);
    end
  end

endmodule

// File: design/cdam_top.v
`timescale 1ns/100ps
`include "cdam_map.vh"

module cdam_top (
  input wire clk_sys, // System clock, 250 MHz
  input wire rst_b, // Synchronous reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  input wire [7:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  output reg [7:0] reg_rdata, // Read data, one cycle after strobe
  input wire run_bit, // Run bit of the configuration register
  input wire [1:0] cfg_mode, // Input configuration
  input wire [7:0] alarm_evt, // Limit exceeded pulses, per slot
  input wire conv_valid, // Conversion result valid
  input wire [2:0] conv_slot, // Slot of the result
  input wire [11:0] conv_data, // Conversion result
  output reg read_wr, // Reading register write pulse
  output reg [2:0] read_slot, // Reading register slot
  output reg [11:0] read_data, // Reading register data
  output reg readings_clr, // Clear all reading registers
  input wire seq_adv, // Sequencer done with current slot
  output reg [2:0] seq_slot, // Slot to convert next
  output reg seq_active, // A slot is presented
  output wire [7:0] chan_skip, // Disabled slots
  output wire [7:0] chan_gate, // Masked slots
  output wire rate_sel, // Conversion rate select
  output wire write_in_run, // Disable written while running
  output wire int_b // Interrupt output, active low
);

  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  localparam [2:0] SQ_IDLE = 3'b001;
  localparam [2:0] SQ_LOAD = 3'b010;
  localparam [2:0] SQ_STEP = 3'b100;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  reg [7:0] skip_r;
  reg [7:0] skip_nxt;
  reg [7:0] gate_r;
  reg [7:0] gate_nxt;
  reg [7:0] pace_r;
  reg [7:0] pace_nxt;
  reg [7:0] rdata_nxt;
  reg [2:0] sq_state_r;
  reg [2:0] sq_state_nxt;
  reg [2:0] seq_slot_nxt;
  reg seq_active_nxt;
  reg read_wr_nxt;
  reg [2:0] read_slot_nxt;
  reg [11:0] read_data_nxt;
  reg viol_r;
  wire [7:0] legal_bits;
  wire [7:0] stat_r;
  wire [7:0] live_bits;
  wire wr_skip;
  wire wr_gate;
  wire wr_pace;
  wire rd_stat;
  wire [3:0] first_live;
  wire [3:0] after_cur;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Next enabled slot after cur, wrapping; msb set when none
  function [3:0] next_live;
    input [2:0] cur;
    input [7:0] live;
    integer i;
    reg [2:0] cand;
    reg [3:0] sum;
    reg found;
    begin
      next_live = 4'h8;
      found = 1'b0;
      cand = cur;
      for (i = 1; i <= 8; i = i + 1) begin
        // Four-bit sum, cut on purpose so the search wraps past seven
        sum = {1'b0, cur} + {1'b0, i[2:0]};
        cand = sum[2:0];
        if (!found && live[cand]) begin
          next_live = {1'b0, cand};
          found = 1'b1;
        end
      end
    end
  endfunction

  // Keep implemented bits only; others read as zero
  function [7:0] keep_legal;
    input [7:0] value;
    input [7:0] legal;
    begin
      keep_legal = value & legal;
    end
  endfunction

  // --------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------
  cdam_mode_mask u_mode_mask (
    .cfg_mode(cfg_mode),
    .legal_bits(legal_bits)
  );

  cdam_alarm_status u_alarm_status (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .alarm_evt(alarm_evt),
    .legal_bits(legal_bits),
    .skip_bits(chan_skip),
    .gate_bits(chan_gate),
    .clr_all(wr_skip),
    .clr_read(rd_stat),
    .stat_r(stat_r),
    .int_b_r(int_b)
  );

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  assign wr_skip = reg_wr && (reg_addr == `CDAM_OFF_SKIP);
  assign wr_gate = reg_wr && (reg_addr == `CDAM_OFF_GATE);
  assign wr_pace = reg_wr && (reg_addr == `CDAM_OFF_PACE);
  // A status read that meets a write leaves the status alone
  assign rd_stat = reg_rd && !reg_wr && (reg_addr == `CDAM_OFF_STAT);

  // Outputs seen by the rest of the device follow the live mode
  assign chan_skip = keep_legal(skip_r, legal_bits);
  assign chan_gate = keep_legal(gate_r, legal_bits);
  assign rate_sel = pace_r[`CDAM_PACE_RATE_BIT];
  assign live_bits = legal_bits & ~chan_skip;
  assign write_in_run = viol_r;

  // Search from slot seven so that slot zero is tried first
  assign first_live = next_live(3'h7, live_bits);
  assign after_cur = next_live(seq_slot, live_bits);

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always @* begin
    skip_nxt = skip_r;
    gate_nxt = gate_r;
    pace_nxt = pace_r;
    if (wr_skip) begin
      // Reserved positions are not stored
      skip_nxt = keep_legal(reg_wdata, legal_bits);
    end
    if (wr_gate) begin
      gate_nxt = keep_legal(reg_wdata, legal_bits);
    end
    if (wr_pace) begin
      pace_nxt = reg_wdata & `CDAM_PACE_LEGAL;
    end
  end

  // --------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------
  always @* begin
    // Mask and disable views are masked to the live mode; status is read as stored and keeps bits set in an earlier mode
    rdata_nxt = `CDAM_RDATA_NONE;
    if (reg_addr == `CDAM_OFF_STAT) begin
      rdata_nxt = stat_r;
    end else if (reg_addr == `CDAM_OFF_GATE) begin
      rdata_nxt = chan_gate;
    end else if (reg_addr == `CDAM_OFF_PACE) begin
      rdata_nxt = pace_r;
    end else if (reg_addr == `CDAM_OFF_SKIP) begin
      rdata_nxt = chan_skip;
    end else begin
      rdata_nxt = `CDAM_RDATA_NONE;
    end
  end

  // --------------------------------------------------------------
  // Reading path
  // --------------------------------------------------------------
  // A disabled slot never carries a converted value to its reading
  // A result that meets a disable write is dropped; the clear wins
  always @* begin
    read_wr_nxt = 1'b0;
    read_slot_nxt = read_slot;
    read_data_nxt = read_data;
    if (conv_valid && legal_bits[conv_slot] && !wr_skip) begin
      read_wr_nxt = 1'b1;
      read_slot_nxt = conv_slot;
      if (chan_skip[conv_slot]) begin
        read_data_nxt = `CDAM_READ_ZERO;
      end else begin
        read_data_nxt = conv_data;
      end
    end
  end

  // --------------------------------------------------------------
  // Slot sequencer
  // --------------------------------------------------------------
  // Shutdown holds the sequencer idle; a disable write restarts it
  always @* begin
    sq_state_nxt = sq_state_r;
    seq_slot_nxt = seq_slot;
    seq_active_nxt = seq_active;
    case (sq_state_r)
      SQ_IDLE: begin
        seq_active_nxt = 1'b0;
        if (run_bit) begin
          sq_state_nxt = SQ_LOAD;
        end
      end
      SQ_LOAD: begin
        if (!run_bit || wr_skip) begin
          sq_state_nxt = SQ_IDLE;
          seq_active_nxt = 1'b0;
        end else if (!first_live[3]) begin
          seq_slot_nxt = first_live[2:0];
          seq_active_nxt = 1'b1;
          sq_state_nxt = SQ_STEP;
        end else begin
          seq_active_nxt = 1'b0;
        end
      end
      SQ_STEP: begin
        if (!run_bit || wr_skip) begin
          sq_state_nxt = SQ_IDLE;
          seq_active_nxt = 1'b0;
        end else if (!live_bits[seq_slot]) begin
          // Mode change removed the presented slot
          sq_state_nxt = SQ_LOAD;
          seq_active_nxt = 1'b0;
        end else if (seq_adv) begin
          seq_slot_nxt = after_cur[2:0];
        end
      end
      default: begin
        sq_state_nxt = SQ_IDLE;
        seq_active_nxt = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      skip_r <= `CDAM_RST_SKIP;
      gate_r <= `CDAM_RST_GATE;
      pace_r <= `CDAM_RST_PACE;
      reg_rdata <= `CDAM_RDATA_NONE;
      readings_clr <= 1'b0;
      read_wr <= 1'b0;
      read_slot <= `CDAM_SLOT_FIRST;
      read_data <= `CDAM_READ_ZERO;
      sq_state_r <= SQ_IDLE;
      seq_slot <= `CDAM_SLOT_FIRST;
      seq_active <= 1'b0;
      viol_r <= 1'b0;
    end else if (ce) begin
      skip_r <= skip_nxt;
      gate_r <= gate_nxt;
      pace_r <= pace_nxt;
      // Read data stands until the next read strobe
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
      // One-cycle pulse tells the reading store to clear
      readings_clr <= wr_skip;
      read_wr <= read_wr_nxt;
      read_slot <= read_slot_nxt;
      read_data <= wr_skip ? `CDAM_READ_ZERO : read_data_nxt;
      sq_state_r <= sq_state_nxt;
      seq_slot <= seq_slot_nxt;
      seq_active <= seq_active_nxt;
      // Write still taken; flag shows the host broke the shutdown rule
      viol_r <= wr_skip && run_bit;
    end
  end

endmodule

// File: bench/cdam_top_asserts.sv
`timescale 1ns/100ps
module cdam_top_asserts (
  input wire clk_sys, // Clock
  input wire rst_b, // Reset
  input wire ce, // Enable
  input wire reg_wr, // Write
  input wire reg_rd, // Read
  input wire [7:0] reg_addr, // Address
  input wire [7:0] reg_rdata, // Read data
  input wire run_bit, // Run
  input wire [1:0] cfg_mode, // Mode
  input wire [7:0] alarm_evt, // Events
  input wire conv_valid, // Result valid
  input wire [2:0] conv_slot, // Result slot
  input wire read_wr, // Reading write
  input wire [11:0] read_data, // Reading data
  input wire readings_clr, // Clear
  input wire seq_active, // Slot shown
  input wire [2:0] seq_slot, // Slot
  input wire [7:0] chan_skip, // Disabled
  input wire [7:0] chan_gate, // Masked
  input wire write_in_run, // Late write
  input wire int_b // Interrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire dis_wr = ce && reg_wr && reg_addr == 8'h08;
  property p_rate;
    ce && reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_rate: assert property (p_rate) else $error("rate spare bits");
  property p_gate_m3;
    cfg_mode == 2'h3 |-> !chan_gate[6];
  endproperty
  a_gate_m3: assert property (p_gate_m3) else $error("mask bit6");
  property p_skip_m2;
    cfg_mode == 2'h2 |-> chan_skip[6:4] == 3'h0;
  endproperty
  a_skip_m2: assert property (p_skip_m2) else $error("skip 4-6");
  property p_int;
    ce && cfg_mode == 2'h1 && |(alarm_evt & ~chan_skip & ~chan_gate)
      |=> !int_b;
  endproperty
  a_int: assert property (p_int) else $error("no interrupt");
  property p_mask;
    int_b && (alarm_evt & ~chan_gate & ~chan_skip) == 8'h00 && !reg_wr
      && !$past(reg_wr) && $past(ce) && $stable(cfg_mode) |=> int_b;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_zero;
    ce && cfg_mode == 2'h1 && conv_valid && chan_skip[conv_slot] && !reg_wr
      |=> read_wr && read_data == 12'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("reading not 0");
  property p_clr;
    dis_wr |=> readings_clr ##1
      (!readings_clr || $past(dis_wr) || !$past(ce));
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_seq;
    seq_active && !$past(reg_wr) |-> !chan_skip[seq_slot];
  endproperty
  a_seq: assert property (p_seq) else $error("skipped slot");
  property p_run;
    dis_wr && run_bit |=> write_in_run;
  endproperty
  a_run: assert property (p_run) else $error("late write");
  c_int: cover property ($fell(int_b));
  c_rd: cover property (read_wr);
  c_clr: cover property (readings_clr);
endmodule

bind cdam_top cdam_top_asserts i_cdam_top_asserts (.clk_sys(clk_sys),
  .rst_b(rst_b), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .run_bit(run_bit),
  .cfg_mode(cfg_mode), .alarm_evt(alarm_evt), .conv_valid(conv_valid),
  .conv_slot(conv_slot), .read_wr(read_wr), .read_data(read_data),
  .readings_clr(readings_clr), .seq_active(seq_active),
  .seq_slot(seq_slot), .chan_skip(chan_skip), .chan_gate(chan_gate),
  .write_in_run(write_in_run), .int_b(int_b));

// File: bench/cdam_host.sv
`timescale 1ns/100ps
module cdam_host (
  input wire clk_sys, // Clock
  input wire [7:0] reg_rdata, // Read data
  output logic reg_wr = 1'b0, // Write
  output logic reg_rd = 1'b0, // Read
  output logic [7:0] reg_addr = 8'h00, // Address
  output logic [7:0] reg_wdata = 8'h00 // Data
);
  // Each scenario decides whether a disable write falls in shutdown
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// File: bench/cdam_top_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module cdam_top_bench;
  logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, run_bit = 1'b0;
  logic conv_valid = 1'b0, seq_adv = 1'b0;
  logic [1:0] cfg_mode = 2'h0;
  logic [7:0] alarm_evt = 8'h00, d;
  logic [2:0] conv_slot = 3'h0, seq_slot, read_slot;
  logic [11:0] conv_data = 12'h000, read_data;
  logic reg_wr, reg_rd, read_wr, readings_clr, seq_active, int_b;
  logic rate_sel, write_in_run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, chan_skip, chan_gate;
  int error_cnt = 0, n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  cdam_host i_cdam_host (.clk_sys(clk_sys),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  cdam_top i_cdam_top (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .run_bit(run_bit),
    .cfg_mode(cfg_mode), .alarm_evt(alarm_evt), .conv_valid(conv_valid),
    .conv_slot(conv_slot), .conv_data(conv_data), .read_wr(read_wr),
    .read_slot(read_slot), .read_data(read_data),
    .readings_clr(readings_clr), .seq_adv(seq_adv), .seq_slot(seq_slot),
    .seq_active(seq_active), .chan_skip(chan_skip), .chan_gate(chan_gate),
    .rate_sel(rate_sel), .write_in_run(write_in_run), .int_b(int_b));
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task pulse_evt(input logic [7:0] e);
    @(posedge clk_sys) alarm_evt <= e;
    @(posedge clk_sys) alarm_evt <= 8'h00;
    #1;
  endtask
  task t_regs;
    logic [7:0] legal [4] = '{8'hff, 8'hff, 8'h8f, 8'hbf};
    i_cdam_host.rd(8'h07, d); `CHK(d, 8'h00)
    i_cdam_host.wr(8'h07, 8'hff);
    i_cdam_host.rd(8'h07, d); `CHK(d, 8'h01)
    `CHK(rate_sel, 1'b1)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys) cfg_mode <= m[1:0];
      i_cdam_host.wr(8'h08, 8'hff);
      i_cdam_host.rd(8'h08, d); `CHK(d, legal[m])
    end
    i_cdam_host.wr(8'h03, 8'hff);
    i_cdam_host.rd(8'h03, d); `CHK(d, 8'hbf)
    `CHK(chan_gate, 8'hbf)
    i_cdam_host.wr(8'h08, 8'h00);
  endtask
  task t_mask;
    i_cdam_host.wr(8'h03, 8'h04);
    pulse_evt(8'h04); `CHK(int_b, 1'b1)
    pulse_evt(8'h02); `CHK(int_b, 1'b0)
    i_cdam_host.rd(8'h01, d); `CHK(d, 8'h06)
    @(posedge clk_sys); #1 `CHK(int_b, 1'b1)
    // Events while the clock enable is low must leave no trace
    @(posedge clk_sys) ce <= 1'b0;
    pulse_evt(8'h02); `CHK(int_b, 1'b1)
    @(posedge clk_sys) ce <= 1'b1;
    i_cdam_host.rd(8'h01, d); `CHK(d, 8'h00)
  endtask
  task t_skip;
    @(posedge clk_sys) cfg_mode <= 2'h1;
    pulse_evt(8'h01);
    i_cdam_host.wr(8'h08, 8'h08);
    #1 `CHK(readings_clr, 1'b1)
    `CHK(int_b, 1'b1)
    `CHK(write_in_run, 1'b0)
    i_cdam_host.rd(8'h01, d); `CHK(d, 8'h00)
    for (int s = 3; s > 1; s--) begin
      @(posedge clk_sys) begin conv_valid <= 1'b1; conv_slot <= s[2:0]; end
      conv_data <= 12'habc;
      @(posedge clk_sys) conv_valid <= 1'b0;
      #1 `CHK(read_data, (s == 3) ? 12'h000 : 12'habc)
      `CHK(read_wr, 1'b1)
      `CHK(read_slot, s[2:0])
    end
    pulse_evt(8'h08); `CHK(int_b, 1'b1)
    // Same value again, still in shutdown: the readings must clear
    i_cdam_host.wr(8'h08, 8'h08);
    #1 `CHK(read_data, 12'h000)
  endtask
  task t_seq;
    int n;
    logic [2:0] exp;
    @(posedge clk_sys) run_bit <= 1'b1;
    n = 0;
    exp = 3'h0;
    while (seq_active !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      if (++n > 20) begin error_cnt++; print_verdict(); end
    end
    for (int k = 0; k < 10; k++) begin
      `CHK(seq_slot == 3'h3, 1'b0)
      `CHK(seq_slot, exp)
      // Slot three is disabled, so the order jumps from two to four
      exp = (exp == 3'h2) ? 3'h4 : exp + 3'h1;
      @(posedge clk_sys) seq_adv <= 1'b1;
      @(posedge clk_sys) seq_adv <= 1'b0;
      #1;
    end
    // Deliberate write while running: taken, flagged, sequencer stops
    i_cdam_host.wr(8'h08, 8'h08);
    #1 `CHK(write_in_run, 1'b1)
    `CHK(seq_active, 1'b0)
    @(posedge clk_sys) run_bit <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_mask();
    t_skip();
    t_seq();
    print_verdict();
  end
endmodule
